//--- pkg/sfw_defines.svh
// Purpose: constants of the software fault watchdog
// Assumes: pclk is the cpu machine-cycle clock
// Notes:   register indices times four give byte addresses
`ifndef SFW_DEFINES_SVH
`define SFW_DEFINES_SVH

// register indices, byte address is index * 4
`define SFW_IDX_CTRL      8'h2a
`define SFW_IDX_STATUS    8'h2b
`define SFW_IDX_EVENTS    8'h2c
`define SFW_IDX_MASK      8'h2d

// control register layout and reset value
`define SFW_ARM_BIT       7
`define SFW_TOP_BIT       6
`define SFW_CTRL_RESET    8'h7f
`define SFW_CNT_EXPIRE    7'h40
`define SFW_FLAG_BIT      0

// event status bits
`define SFW_EV_TIMEOUT    0
`define SFW_EV_HALT       1
`define SFW_EV_SOFT       2
`define SFW_EV_W          3

// machine cycles per countdown step (12288)
`define SFW_STEP_CYCLES   14'h3000

// reset pulse timing
`define SFW_CLK_NS        50
`define SFW_PULSE_NS      500
`define SFW_PULSE_CYC     ((`SFW_PULSE_NS + `SFW_CLK_NS - 1) / `SFW_CLK_NS)

// status register present only with undervoltage detect reset
`define SFW_HAS_STATUS    1'h1

`endif

//--- pkg/sfw_pkg.sv
// Purpose: types of the software fault watchdog
// Assumes: constants come from sfw_defines.svh
// Notes:   all block state is one packed struct
`default_nettype none

package sfw_pkg;

	typedef enum logic [0:0] {SFW_IDLE, SFW_PULSE} sfw_state_t;

	typedef struct packed {
		sfw_state_t  fsm;
		logic [7:0]  ctrl;
		logic        flag;
		logic [13:0] presc;
		logic [3:0]  pulse_cnt;
		logic        chip_reset_n;
		logic [2:0]  events;
		logic [2:0]  mask;
		logic        irq;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} sfw_regs_t;

endpackage : sfw_pkg

`default_nettype wire

//--- hw/sfw_watchdog.sv
// Purpose: software fault watchdog with apb register access
// Assumes: inputs synchronous to pclk, pclk is the machine cycle
// Notes:   reset pulse drives chip_reset_n low for a fixed width
//
// Summary of operation
// RL1 - count in control bits 6:0 steps down once per 12288 machine cycles
// RL2 - lower six count bits give 64 selectable timeout lengths
// RL3 - armed count rolling 40h to 3Fh starts a 500 ns reset pulse
// RL4 - software reloads the control register with FFh down to C0h periodically
// RL5 - every reload sets the arm bit and the top count bit
// RL6 - at 8 MHz FFh gives 98.304 ms and C0h gives 1.536 ms
// RL7 - disarmed after any reset; once armed only a reset disarms
// RL8 - arm bit 7 set by software, cleared only by reset; one allows resets
// RL9 - writing arm set with top count bit clear gives a software reset
// RL10 - halt instruction while armed gives an immediate reset
// RL11 - hardware option keeps the watchdog armed, arm bit then unused
// RL12 - wait state leaves counting and reset behaviour unchanged
// RL13 - control register resets to 7Fh, disarmed with count bits all one
// RL14 - status flag bit 0 set by watchdog reset, cleared by write or power reset
// RL15 - status register exists only with undervoltage detect reset
// RL16 - no interrupt request of the watchdog itself, expiry only resets; here expiry also sets events bit 0, and irq is the masked event summary
// RL17 - reset pulse width timed by a cycle counter at the clock rate
`timescale 1ns/100ps
`include "sfw_defines.svh"
`default_nettype none

module sfw_watchdog (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic        pready,
	output var  logic [31:0] prdata,
	output var  logic        pslverr,
	input  wire logic        halt_exec,
	input  wire logic        hw_watchdog_opt,
	output var  logic        chip_reset_n,
	output var  logic        irq
);

	sfw_pkg::sfw_regs_t s;
	sfw_pkg::sfw_regs_t next_s;

	logic        access;
	logic        wr_ctrl;
	logic        wr_status;
	logic        wr_mask;
	logic        rd_events;
	logic        armed;
	logic        tick;
	logic        trig_timeout;
	logic        trig_soft;
	logic        trig_halt;
	logic [2:0]  ev_set;
	logic [31:0] rd_mux;
	logic        mapped;

	// byte address of a register index
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] idx);
		logic [9:0] byte_addr;
		byte_addr = {idx, 2'h0};
		addr_hit = ({2'h0, addr} == byte_addr);
	endfunction : addr_hit

	assign access    = psel & penable & s.pready;
	assign wr_ctrl   = access & pwrite & addr_hit(paddr, `SFW_IDX_CTRL);
	assign wr_status = access & pwrite & addr_hit(paddr, `SFW_IDX_STATUS);
	assign wr_mask   = access & pwrite & addr_hit(paddr, `SFW_IDX_MASK);
	assign rd_events = access & ~pwrite & addr_hit(paddr, `SFW_IDX_EVENTS);

	// hardware option forces arming
	assign armed = s.ctrl[`SFW_ARM_BIT] | hw_watchdog_opt; // RL11 RL8

	// one step per 12288 machine cycles, wait state not seen here
	assign tick = (s.fsm == sfw_pkg::SFW_IDLE) && (s.presc == `SFW_STEP_CYCLES - 14'h0001); // RL1 RL12

	// 40h to 3Fh roll, a reload in the same cycle wins
	assign trig_timeout = tick && armed && !wr_ctrl
		&& (s.ctrl[6:0] == `SFW_CNT_EXPIRE); // RL3 RL2 RL6

	// top count bit written clear with the watchdog armed or the arm bit written set
	assign trig_soft = wr_ctrl && (armed || pwdata[`SFW_ARM_BIT])
		&& !pwdata[`SFW_TOP_BIT]; // RL9 RL5

	assign trig_halt = halt_exec && armed; // RL10

	always_comb
	begin
		ev_set = 3'h0;
		if (s.fsm == sfw_pkg::SFW_IDLE)
		begin
			ev_set[`SFW_EV_TIMEOUT] = trig_timeout;
			ev_set[`SFW_EV_HALT]    = trig_halt;
			ev_set[`SFW_EV_SOFT]    = trig_soft;
		end
	end

	always_comb
	begin
		mapped = 1'h1;
		rd_mux = 32'h0000_0000;
		if (addr_hit(paddr, `SFW_IDX_CTRL))
			rd_mux = {24'h00_0000, s.ctrl};
		else if (addr_hit(paddr, `SFW_IDX_STATUS))
			rd_mux = {31'h0000_0000, s.flag & `SFW_HAS_STATUS}; // RL15
		else if (addr_hit(paddr, `SFW_IDX_EVENTS))
			rd_mux = {29'h0000_0000, s.events};
		else if (addr_hit(paddr, `SFW_IDX_MASK))
			rd_mux = {29'h0000_0000, s.mask};
		else
			mapped = 1'h0;
	end

	always_comb
	begin
		next_s = s;

		// apb: one wait state, answer registered
		next_s.pready  = psel & penable & ~s.pready;
		next_s.prdata  = (psel & penable & ~s.pready & ~pwrite) ? rd_mux : 32'h0000_0000;
		next_s.pslverr = psel & penable & ~s.pready & ~mapped;

		if (wr_mask)
			next_s.mask = pwdata[`SFW_EV_W-1:0];
		// clear only what the read returned, a newer event survives
		if (rd_events)
			next_s.events = s.events & ~s.prdata[`SFW_EV_W-1:0];
		next_s.events = next_s.events | ev_set;

		// software write of zero clears the flag
		if (wr_status && !pwdata[`SFW_FLAG_BIT])
			next_s.flag = 1'h0; // RL14

		case (s.fsm)
			sfw_pkg::SFW_IDLE:
			begin
				next_s.presc = tick ? 14'h0000 : s.presc + 14'h0001;
				if (wr_ctrl)
					next_s.ctrl = {s.ctrl[`SFW_ARM_BIT] | pwdata[`SFW_ARM_BIT], pwdata[6:0]}; // RL7 RL8
				else if (tick)
					next_s.ctrl = {s.ctrl[`SFW_ARM_BIT], s.ctrl[6:0] - 7'h01}; // RL1
				if (|ev_set)
				begin
					next_s.fsm          = sfw_pkg::SFW_PULSE;
					next_s.pulse_cnt    = 4'(`SFW_PULSE_CYC - 1); // RL17
					next_s.chip_reset_n = 1'h0; // RL3
					next_s.ctrl         = `SFW_CTRL_RESET; // RL7 RL13
					next_s.presc        = 14'h0000;
					next_s.flag         = `SFW_HAS_STATUS; // RL14
				end
			end
			sfw_pkg::SFW_PULSE:
			begin
				// chip under reset: control held at 7Fh and step counter at zero
				next_s.ctrl  = `SFW_CTRL_RESET; // RL7
				next_s.presc = 14'h0000;
				if (s.pulse_cnt == 4'h0)
				begin
					next_s.fsm          = sfw_pkg::SFW_IDLE;
					next_s.chip_reset_n = 1'h1;
				end
				else
					next_s.pulse_cnt = s.pulse_cnt - 4'h1; // RL17
			end
			default:
			begin
				next_s.fsm          = sfw_pkg::SFW_IDLE;
				next_s.chip_reset_n = 1'h1;
			end
		endcase

		// the only interrupt is the wrapper's event summary
		next_s.irq = |(next_s.events & next_s.mask); // RL16
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s              <= '0;
			s.fsm          <= sfw_pkg::SFW_IDLE;
			s.ctrl         <= `SFW_CTRL_RESET; // RL13
			s.chip_reset_n <= 1'h1;
		end
		else
			s <= next_s;
	end

	assign pready       = s.pready;
	assign prdata       = s.prdata;
	assign pslverr      = s.pslverr;
	assign chip_reset_n = s.chip_reset_n;
	assign irq          = s.irq;

	// checks

	property p_pulse_width;
		@(posedge pclk) disable iff (!presetn)
		$fell(chip_reset_n) |-> !chip_reset_n ##9 !chip_reset_n ##1 chip_reset_n;
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("reset pulse width wrong"); // RL3 RL17

	property p_timeout;
		@(posedge pclk) disable iff (!presetn)
		(s.fsm == sfw_pkg::SFW_IDLE) && armed && tick && !wr_ctrl && (s.ctrl[6:0] == 7'h40)
		|=> !chip_reset_n;
	endproperty
	a_timeout: assert property (p_timeout) else $error("no reset on 40h to 3Fh roll"); // RL3

	property p_no_reset_disarmed;
		@(posedge pclk) disable iff (!presetn)
		(s.fsm == sfw_pkg::SFW_IDLE) && !armed && !pwdata[7] |=> chip_reset_n;
	endproperty
	a_no_reset_disarmed: assert property (p_no_reset_disarmed) else $error("reset while disarmed"); // RL8

	property p_soft;
		@(posedge pclk) disable iff (!presetn)
		(s.fsm == sfw_pkg::SFW_IDLE) && wr_ctrl && pwdata[7] && !pwdata[6] |=> !chip_reset_n;
	endproperty
	a_soft: assert property (p_soft) else $error("no software reset"); // RL9

	property p_halt;
		@(posedge pclk) disable iff (!presetn)
		(s.fsm == sfw_pkg::SFW_IDLE) && halt_exec && (s.ctrl[7] || hw_watchdog_opt) |=> !chip_reset_n;
	endproperty
	a_halt: assert property (p_halt) else $error("halt while armed did not reset"); // RL10

	property p_hw_opt;
		@(posedge pclk) disable iff (!presetn)
		(s.fsm == sfw_pkg::SFW_IDLE) && hw_watchdog_opt && halt_exec |=> !chip_reset_n;
	endproperty
	a_hw_opt: assert property (p_hw_opt) else $error("hardware option not armed"); // RL11

	property p_arm_sticky;
		@(posedge pclk) disable iff (!presetn)
		(s.fsm == sfw_pkg::SFW_IDLE) && s.ctrl[7] && !(|ev_set) |=> s.ctrl[7];
	endproperty
	a_arm_sticky: assert property (p_arm_sticky) else $error("arm bit cleared by software"); // RL7

	property p_disarm_on_reset;
		@(posedge pclk) disable iff (!presetn)
		$fell(chip_reset_n) |-> (s.ctrl == 8'h7f) ##1 (s.ctrl == 8'h7f);
	endproperty
	a_disarm_on_reset: assert property (p_disarm_on_reset) else $error("control not 7Fh in reset"); // RL7 RL13

	property p_decrement;
		@(posedge pclk) disable iff (!presetn)
		tick && !wr_ctrl && !(|ev_set) |=> (s.ctrl[6:0] == $past(s.ctrl[6:0]) - 7'h01);
	endproperty
	a_decrement: assert property (p_decrement) else $error("count did not step down"); // RL1

	property p_step_hold;
		@(posedge pclk) disable iff (!presetn)
		(s.fsm == sfw_pkg::SFW_IDLE) && !tick && !wr_ctrl && !(|ev_set) |=> $stable(s.ctrl);
	endproperty
	a_step_hold: assert property (p_step_hold) else $error("count moved between steps"); // RL1 RL2

	property p_flag_set;
		@(posedge pclk) disable iff (!presetn)
		$fell(chip_reset_n) |-> s.flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set by watchdog reset"); // RL14

	property p_flag_clear;
		@(posedge pclk) disable iff (!presetn)
		wr_status && !pwdata[0] && !(|ev_set) |=> !s.flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write"); // RL14

	property p_apb_answer;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		|(s.events & s.mask) |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq low with unmasked event"); // RL16

	property p_ctrl_write;
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl && (s.fsm == sfw_pkg::SFW_IDLE) && !(|ev_set)
		|=> (s.ctrl[6:0] == $past(pwdata[6:0])) && (s.ctrl[7] == ($past(s.ctrl[7]) || $past(pwdata[7])));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write did not land"); // RL8

	property p_ctrl_in_pulse;
		@(posedge pclk) disable iff (!presetn)
		!chip_reset_n |-> (s.ctrl == `SFW_CTRL_RESET);
	endproperty
	a_ctrl_in_pulse: assert property (p_ctrl_in_pulse) else $error("control moved during reset pulse"); // RL7

	property p_pulse_cause;
		@(posedge pclk) disable iff (!presetn)
		chip_reset_n && !(|ev_set) |=> chip_reset_n;
	endproperty
	a_pulse_cause: assert property (p_pulse_cause) else $error("reset pulse without a cause"); // RL3

	property p_presc_restart;
		@(posedge pclk) disable iff (!presetn)
		$rose(chip_reset_n) |-> (s.presc == 14'h0000);
	endproperty
	a_presc_restart: assert property (p_presc_restart) else $error("step counter not restarted"); // RL1

	property p_presc_bound;
		@(posedge pclk) disable iff (!presetn)
		s.presc < `SFW_STEP_CYCLES;
	endproperty
	a_presc_bound: assert property (p_presc_bound) else $error("step counter out of range"); // RL1

	property p_event_set;
		@(posedge pclk) disable iff (!presetn)
		|ev_set |=> ((s.events & $past(ev_set)) == $past(ev_set));
	endproperty
	a_event_set: assert property (p_event_set) else $error("reset cause not recorded");

	property p_flag_hold;
		@(posedge pclk) disable iff (!presetn)
		s.flag && !wr_status |=> s.flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag lost without a write"); // RL14

	property p_flag_no_set;
		@(posedge pclk) disable iff (!presetn)
		!s.flag && !(|ev_set) |=> !s.flag;
	endproperty
	a_flag_no_set: assert property (p_flag_no_set) else $error("flag set without watchdog reset"); // RL14

	property p_idle_no_ready;
		@(posedge pclk) disable iff (!presetn)
		!(psel && penable) |=> !pready;
	endproperty
	a_idle_no_ready: assert property (p_idle_no_ready) else $error("pready without access");

	property p_slverr_ready;
		@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready;
	endproperty
	a_slverr_ready: assert property (p_slverr_ready) else $error("pslverr without pready");

	property p_prdata_idle;
		@(posedge pclk) disable iff (!presetn)
		!pready |-> (prdata == 32'h0000_0000);
	endproperty
	a_prdata_idle: assert property (p_prdata_idle) else $error("prdata not zero between answers");

	c_timeout: cover property (@(posedge pclk) disable iff (!presetn) trig_timeout);
	c_soft: cover property (@(posedge pclk) disable iff (!presetn) trig_soft);
	c_halt: cover property (@(posedge pclk) disable iff (!presetn) trig_halt);
	c_reload: cover property (@(posedge pclk) disable iff (!presetn) wr_ctrl && pwdata[7] && pwdata[6]);
	c_hw_opt: cover property (@(posedge pclk) disable iff (!presetn) hw_watchdog_opt && trig_halt);

endmodule : sfw_watchdog

`default_nettype wire

//--- dv/tb.sv
// Purpose: self-checking bench for the software fault watchdog
// Assumes: apb answers with one wait state
// Notes:   apb answers checked in order at negedge
`timescale 1ns/100ps
`include "sfw_defines.svh"
`default_nettype none

module tb;
	logic        pclk = 1'b0;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        halt_exec;
	logic        hw_watchdog_opt;
	logic        chip_reset_n;
	logic        irq;
	logic [32:0] exp_q[$];
	logic [32:0] msk_q[$];
	logic [32:0] m;
	logic [31:0] r;
	int          failures;
	int          n_checks;
	int          t;

	sfw_watchdog i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .halt_exec(halt_exec), .hw_watchdog_opt(hw_watchdog_opt),
		.chip_reset_n(chip_reset_n), .irq(irq));

	always #25 pclk = ~pclk;

	task finish_test();
		$display("checks %0d errors %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// scoreboard: oldest note against each answer
	always @(negedge pclk)
		if (pready === 1'b1)
		begin
			m = (msk_q.size() > 0) ? msk_q.pop_front() : 33'h1_ffff_ffff;
			chk("apb answer", ((exp_q.size() > 0) ? exp_q.pop_front() : 33'h0_dead_beef) & m,
				{pslverr, prdata} & m);
		end

	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [32:0] e,
		input logic [32:0] mk);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx[5:0], 2'b00};
		pwdata  <= d;
		exp_q.push_back(e);
		msk_q.push_back(mk);
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(negedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			chk("pready", 1, 0);
			finish_test();
		end
		@(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d, 33'h0, 33'h1_ffff_ffff);
	endtask : wr

	task rd(input logic [7:0] idx, input logic [31:0] e);
		apb(1'b0, idx, 32'h0, {1'b0, e}, 33'h1_ffff_ffff);
	endtask : rd

	// wait for the reset pulse, then measure its width
	task pulse(input int lo, input int hi);
		t = 0;
		while (chip_reset_n !== 1'b0 && t <= hi)
		begin
			@(negedge pclk);
			t++;
		end
		n_checks++;
		if (t < lo || t > hi)
		begin
			failures++;
			$display("[ERR] reset delay exp %0d..%0d got %0d", lo, hi, t);
			if (t > hi)
				finish_test();
		end
		t = 0;
		while (chip_reset_n === 1'b0 && t < 40)
		begin
			@(negedge pclk);
			t++;
		end
		chk("pulse width", `SFW_PULSE_CYC, t);
	endtask : pulse

	task halt();
		@(posedge pclk);
		halt_exec <= 1'b1;
		@(posedge pclk);
		halt_exec <= 1'b0;
	endtask : halt

	initial
	begin
		{presetn, psel, penable, pwrite, halt_exec, hw_watchdog_opt} = 6'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		failures = 0;
		n_checks = 0;
		r = $urandom(32'h0000_a9e3);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(`SFW_IDX_CTRL, 32'h0000_007f);
		rd(`SFW_IDX_STATUS, 32'h0000_0000);
		apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0}, 33'h1_ffff_ffff);
		r = $urandom & 32'h0000_0007;
		wr(`SFW_IDX_MASK, r);
		rd(`SFW_IDX_MASK, r);
		wr(`SFW_IDX_MASK, 32'h0000_0007);
		halt();
		t = 0;
		repeat (20) @(negedge pclk) if (chip_reset_n !== 1'b1) t++;
		chk("disarmed halt", 0, t);
		wr(`SFW_IDX_CTRL, 32'h0000_0080);
		pulse(0, 4);
		rd(`SFW_IDX_CTRL, 32'h0000_007f);
		chk("irq", 1, irq);
		rd(`SFW_IDX_STATUS, 32'h0000_0001);
		rd(`SFW_IDX_EVENTS, 32'h0000_0004);
		@(negedge pclk);
		chk("irq", 0, irq);
		wr(`SFW_IDX_STATUS, 32'h0);
		rd(`SFW_IDX_STATUS, 32'h0);
		wr(`SFW_IDX_MASK, 32'h0);
		wr(`SFW_IDX_CTRL, 32'h0000_00ff);
		wr(`SFW_IDX_CTRL, 32'h0000_007f);
		apb(1'b0, `SFW_IDX_CTRL, 32'h0, 33'h80, 33'h1_0000_0080);
		halt();
		pulse(0, 3);
		rd(`SFW_IDX_EVENTS, 32'h0000_0002);
		chk("masked irq", 0, irq);
		wr(`SFW_IDX_CTRL, 32'h0000_00c0);
		pulse(0, 12300);
		rd(`SFW_IDX_EVENTS, 32'h0000_0001);
		wr(`SFW_IDX_CTRL, 32'h0000_00c1);
		pulse(24555, 24580);
		repeat (3)
		begin
			wr(`SFW_IDX_CTRL, 32'h0000_00c1);
			t = 0;
			repeat (8000) @(negedge pclk) if (chip_reset_n !== 1'b1) t++;
			chk("reloaded", 0, t);
		end
		@(posedge pclk);
		hw_watchdog_opt <= 1'b1;
		halt();
		pulse(0, 3);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(`SFW_IDX_STATUS, 32'h0);
		finish_test();
	end
endmodule : tb

`default_nettype wire
